// ### core/pvm_pkg.sv
// Constants for the vendor mode/status register set of a 10/100 transceiver.
// Assumes registers are reached by a 5-bit register index from the management logic.
//
// Operation
// - Mode control bit 13 enables energy-detect power-down; resets to zero.
// - Bit 9 set retransmits every received packet onto the line, 100BASE-TX only.
// - Far loopback keeps working while the isolate control bit is asserted.
// - Bit 6 selects primary interrupt scheme at 0 (default), alternate at 1.
// - Energy-present bit falls to 0 after 256 ms without valid line energy.
// - Energy-present is forced to 1 by hardware reset, untouched by software reset.
// - Special modes bits 7:5 hold the read-write operating mode the device follows.
// - Operating-mode default is loaded from the three mode straps at reset.
// - Address field 4:0 is the management address and the scrambler seed.
// - Address field default comes from the single address strap pin.
// - In 100BASE-TX the symbol error counter advances on invalid symbols, idle included.
// - The counter advances at most once per received packet.
// - The counter wraps from its maximum to zero and keeps counting.
// - Reset clears the counter; reading it leaves it unchanged.
// - The counter holds and never advances in 10BASE-T mode.
// - Special control bit 15 clear means auto crossover; set means bit 13 decides.
// - Manual select 0 gives straight wiring, 1 gives crossed wiring.
// - Special control bit 11 set disables the SQE heartbeat test; default enabled.
// - Read-only bit 4 reports 10BASE-T receive polarity, 1 for reversed.

package pvm_pkg;

  // ==========================================================================
  // Register indexes
  localparam logic [4:0] PVM_IDX_MODE_CTL = 5'h11;
  localparam logic [4:0] PVM_IDX_SPECIAL_MODES = 5'h12;
  localparam logic [4:0] PVM_IDX_SYM_ERR = 5'h1A;
  localparam logic [4:0] PVM_IDX_XOVER_CTL = 5'h1B;

  // ==========================================================================
  // Field positions
  localparam int PVM_BIT_EDPD_EN = 13;
  localparam int PVM_BIT_LOOPBACK_EN = 9;
  localparam int PVM_BIT_IRQ_SCHEME = 6;
  localparam int PVM_BIT_ENERGY = 1;
  localparam int PVM_BIT_MODE_RSVD_RW = 0;
  localparam int PVM_BIT_SM_RSVD_RW = 14;
  localparam int PVM_MODE_MSB = 7;
  localparam int PVM_MODE_LSB = 5;
  localparam int PVM_ADDR_MSB = 4;
  localparam int PVM_ADDR_LSB = 0;
  localparam int PVM_BIT_XOVER_DIS = 15;
  localparam int PVM_BIT_XOVER_SEL = 13;
  localparam int PVM_BIT_SQE_DIS = 11;
  localparam int PVM_BIT_RX_POL = 4;

  // ==========================================================================
  // Reset values
  localparam logic PVM_RST_SM_RSVD_RW = 1'b1;
  localparam logic PVM_RST_ENERGY = 1'b1;
  localparam logic [2:0] PVM_RST_MODE = 3'h0;
  localparam logic [4:0] PVM_RST_ADDR = 5'h00;
  localparam logic [15:0] PVM_RST_SYM_ERR = 16'h0000;

  // ==========================================================================
  // Timing
  localparam int PVM_CLK_KHZ = 125000;
  localparam int PVM_ENERGY_TIMEOUT_MS = 256;
  localparam int PVM_ENERGY_CYCLES = PVM_ENERGY_TIMEOUT_MS * PVM_CLK_KHZ;
  localparam int PVM_ENERGY_CNT_W = 25;

endpackage

// ### core/pvm_regs.sv
// Vendor mode/status registers: power-down, loopback, straps, error count, crossover.
// Assumes one clock, register index port from the management logic, sync inputs.
`timescale 1ns/1ps
`default_nettype none

module pvm_regs #(
  parameter int ENERGY_CYCLES = pvm_pkg::PVM_ENERGY_CYCLES
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic ce_i,
  input wire logic soft_rst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [15:0] reg_wdata_i,
  output logic [15:0] reg_rdata_o,
  input wire logic [2:0] mode_strap_i,
  input wire logic addr_strap_i,
  input wire logic speed_100_i,
  input wire logic isolate_i,
  input wire logic energy_detect_i,
  input wire logic rx_packet_i,
  input wire logic rx_symbol_err_i,
  input wire logic rx_dv_i,
  input wire logic [3:0] rx_data_i,
  input wire logic auto_mdix_i,
  input wire logic rx_polarity_reversed_i,
  output logic energy_detect_powerdown_en_o,
  output logic irq_scheme_select_o,
  output logic [2:0] op_mode_o,
  output logic [4:0] mgmt_address_o,
  output logic lb_tx_en_o,
  output logic [3:0] lb_tx_data_o,
  output logic mdix_active_o,
  output logic heartbeat_test_en_o
);
  import pvm_pkg::*;

  // ==========================================================================
  // Decode helpers
  function automatic logic hit(input logic [4:0] addr, input logic [4:0] idx);
    hit = (addr == idx);
  endfunction

  logic wr_mode_ctl;
  logic wr_special;
  logic wr_xover;
  assign wr_mode_ctl = ce_i && reg_wr_i && hit(reg_addr_i, PVM_IDX_MODE_CTL);
  assign wr_special = ce_i && reg_wr_i && hit(reg_addr_i, PVM_IDX_SPECIAL_MODES);
  assign wr_xover = ce_i && reg_wr_i && hit(reg_addr_i, PVM_IDX_XOVER_CTL);

  // ==========================================================================
  // Mode control register
  logic edpd_en_q;
  logic line_side_loopback_en_q;
  logic irq_scheme_select_q;
  logic mode_rsvd_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      edpd_en_q <= 1'b0;
      line_side_loopback_en_q <= 1'b0;
      irq_scheme_select_q <= 1'b0;
      mode_rsvd_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_rst_i) begin
        edpd_en_q <= 1'b0;
        line_side_loopback_en_q <= 1'b0;
        irq_scheme_select_q <= 1'b0;
        mode_rsvd_q <= 1'b0;
      end else if (wr_mode_ctl) begin
        edpd_en_q <= reg_wdata_i[PVM_BIT_EDPD_EN];
        line_side_loopback_en_q <= reg_wdata_i[PVM_BIT_LOOPBACK_EN];
        irq_scheme_select_q <= reg_wdata_i[PVM_BIT_IRQ_SCHEME];
        mode_rsvd_q <= reg_wdata_i[PVM_BIT_MODE_RSVD_RW];
      end
    end
  end

  assign energy_detect_powerdown_en_o = edpd_en_q;
  assign irq_scheme_select_o = irq_scheme_select_q;

  // ==========================================================================
  // Energy-present status and its quiet-line timer
  // Soft reset is deliberately absent here: the flag survives it.
  logic line_energy_present_q;
  logic [PVM_ENERGY_CNT_W-1:0] energy_timer_q;
  localparam logic [PVM_ENERGY_CNT_W-1:0] ENERGY_LAST = PVM_ENERGY_CNT_W'(ENERGY_CYCLES - 1);
  logic energy_expire;
  assign energy_expire = !energy_detect_i && (energy_timer_q == ENERGY_LAST);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      line_energy_present_q <= PVM_RST_ENERGY;
      energy_timer_q <= '0;
    end else if (ce_i) begin
      if (energy_detect_i) begin
        line_energy_present_q <= 1'b1;
        energy_timer_q <= '0;
      end else if (energy_expire) begin
        line_energy_present_q <= 1'b0;
      end else begin
        energy_timer_q <= energy_timer_q + 1'b1;
      end
    end
  end

  // ==========================================================================
  // Special modes register; strap defaults are caught after reset release
  logic strap_done_q;
  logic sm_rsvd_q;
  logic [2:0] op_mode_q;
  logic [4:0] mgmt_address_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      strap_done_q <= 1'b0;
      sm_rsvd_q <= PVM_RST_SM_RSVD_RW;
      op_mode_q <= PVM_RST_MODE;
      mgmt_address_q <= PVM_RST_ADDR;
    end else if (ce_i) begin
      if (!strap_done_q) begin
        strap_done_q <= 1'b1;
        op_mode_q <= mode_strap_i;
        mgmt_address_q <= {4'h0, addr_strap_i};
      end else if (wr_special) begin
        sm_rsvd_q <= reg_wdata_i[PVM_BIT_SM_RSVD_RW];
        op_mode_q <= reg_wdata_i[PVM_MODE_MSB:PVM_MODE_LSB];
        mgmt_address_q <= reg_wdata_i[PVM_ADDR_MSB:PVM_ADDR_LSB];
      end
    end
  end

  assign op_mode_o = op_mode_q;
  // Same field feeds the management address match and the scrambler seed
  assign mgmt_address_o = mgmt_address_q;

  // ==========================================================================
  // Symbol error counter
  logic pkt_err_seen_q;
  logic [15:0] invalid_symbol_count_q;
  logic count_step;
  assign count_step = speed_100_i && rx_symbol_err_i && !(rx_packet_i && pkt_err_seen_q);

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      pkt_err_seen_q <= 1'b0;
    end else if (ce_i) begin
      if (!rx_packet_i || soft_rst_i) begin
        pkt_err_seen_q <= 1'b0;
      end else if (speed_100_i && rx_symbol_err_i) begin
        pkt_err_seen_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      invalid_symbol_count_q <= PVM_RST_SYM_ERR;
    end else if (ce_i) begin
      if (soft_rst_i) begin
        invalid_symbol_count_q <= PVM_RST_SYM_ERR;
      end else if (count_step) begin
        // Natural 16-bit wrap to zero after the maximum
        invalid_symbol_count_q <= invalid_symbol_count_q + 16'h0001;
      end
    end
  end

  // ==========================================================================
  // Crossover, heartbeat and polarity
  logic auto_crossover_disable_q;
  logic manual_crossover_select_q;
  logic heartbeat_test_disable_q;
  logic mdix_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      auto_crossover_disable_q <= 1'b0;
      manual_crossover_select_q <= 1'b0;
      heartbeat_test_disable_q <= 1'b0;
    end else if (ce_i) begin
      if (soft_rst_i) begin
        auto_crossover_disable_q <= 1'b0;
        manual_crossover_select_q <= 1'b0;
      end else if (wr_xover) begin
        auto_crossover_disable_q <= reg_wdata_i[PVM_BIT_XOVER_DIS];
        manual_crossover_select_q <= reg_wdata_i[PVM_BIT_XOVER_SEL];
        heartbeat_test_disable_q <= reg_wdata_i[PVM_BIT_SQE_DIS];
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      mdix_q <= 1'b0;
    end else if (ce_i) begin
      mdix_q <= auto_crossover_disable_q ? manual_crossover_select_q : auto_mdix_i;
    end
  end

  assign mdix_active_o = mdix_q;
  assign heartbeat_test_en_o = !heartbeat_test_disable_q;

  // ==========================================================================
  // Far loopback: isolate is not consulted, so the path runs while isolated
  logic lb_tx_en_q;
  logic [3:0] lb_tx_data_q;

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      lb_tx_en_q <= 1'b0;
      lb_tx_data_q <= 4'h0;
    end else if (ce_i) begin
      lb_tx_en_q <= line_side_loopback_en_q && speed_100_i && rx_dv_i;
      lb_tx_data_q <= rx_data_i;
    end
  end

  assign lb_tx_en_o = lb_tx_en_q;
  assign lb_tx_data_o = lb_tx_data_q;

  // ==========================================================================
  // Read port, one cycle latency, no side effects on any register
  logic [15:0] rdata_d;
  logic [15:0] rdata_q;

  always_comb begin
    rdata_d = 16'h0000;
    if (hit(reg_addr_i, PVM_IDX_MODE_CTL)) begin
      rdata_d[PVM_BIT_EDPD_EN] = edpd_en_q;
      rdata_d[PVM_BIT_LOOPBACK_EN] = line_side_loopback_en_q;
      rdata_d[PVM_BIT_IRQ_SCHEME] = irq_scheme_select_q;
      rdata_d[PVM_BIT_ENERGY] = line_energy_present_q;
      rdata_d[PVM_BIT_MODE_RSVD_RW] = mode_rsvd_q;
    end else if (hit(reg_addr_i, PVM_IDX_SPECIAL_MODES)) begin
      rdata_d[PVM_BIT_SM_RSVD_RW] = sm_rsvd_q;
      rdata_d[PVM_MODE_MSB:PVM_MODE_LSB] = op_mode_q;
      rdata_d[PVM_ADDR_MSB:PVM_ADDR_LSB] = mgmt_address_q;
    end else if (hit(reg_addr_i, PVM_IDX_SYM_ERR)) begin
      rdata_d = invalid_symbol_count_q;
    end else if (hit(reg_addr_i, PVM_IDX_XOVER_CTL)) begin
      rdata_d[PVM_BIT_XOVER_DIS] = auto_crossover_disable_q;
      rdata_d[PVM_BIT_XOVER_SEL] = manual_crossover_select_q;
      rdata_d[PVM_BIT_SQE_DIS] = heartbeat_test_disable_q;
      rdata_d[PVM_BIT_RX_POL] = rx_polarity_reversed_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rdata_q <= 16'h0000;
    end else if (ce_i && reg_rd_i) begin
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata_o = rdata_q;

  // ==========================================================================
  // Checks
  AST_EDPD_WRITE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_mode_ctl && !soft_rst_i)
      |=> energy_detect_powerdown_en_o == $past(reg_wdata_i[PVM_BIT_EDPD_EN]))
    else $error("power-down enable did not follow write");

  AST_LOOPBACK_ECHO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && line_side_loopback_en_q && speed_100_i && rx_dv_i)
      |=> lb_tx_en_o && lb_tx_data_o == $past(rx_data_i))
    else $error("far loopback failed to echo receive data");

  AST_LOOPBACK_ISOLATE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && isolate_i && line_side_loopback_en_q && speed_100_i && rx_dv_i) |=> lb_tx_en_o)
    else $error("far loopback stopped under isolate");

  AST_LOOPBACK_10M: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && !speed_100_i) |=> !lb_tx_en_o)
    else $error("far loopback active in 10BASE-T");

  AST_IRQ_SCHEME: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (wr_mode_ctl && !soft_rst_i)
      |=> irq_scheme_select_o == $past(reg_wdata_i[PVM_BIT_IRQ_SCHEME]))
    else $error("interrupt scheme select did not follow write");

  AST_ENERGY_FALL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && energy_expire) |=> !line_energy_present_q)
    else $error("energy-present did not fall at timeout");

  AST_ENERGY_SOFT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && soft_rst_i && !energy_detect_i)
      |=> line_energy_present_q == $past(line_energy_present_q && !energy_expire))
    else $error("software reset altered energy-present");

  AST_MODE_KEPT: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && strap_done_q && soft_rst_i && !wr_special) |=> $stable(op_mode_o))
    else $error("operating mode lost on software reset");

  AST_SYMERR_IDLE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && !soft_rst_i && speed_100_i && rx_symbol_err_i && !rx_packet_i)
      |=> invalid_symbol_count_q == $past(invalid_symbol_count_q) + 16'h0001)
    else $error("idle symbol error not counted");

  AST_SYMERR_ONCE: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && !soft_rst_i && rx_packet_i && pkt_err_seen_q) |=> $stable(invalid_symbol_count_q))
    else $error("symbol error counted twice in one packet");

  AST_SYMERR_10M: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && !soft_rst_i && !speed_100_i) |=> $stable(invalid_symbol_count_q))
    else $error("symbol error counter moved in 10BASE-T");

  AST_SYMERR_READ: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && reg_rd_i && !soft_rst_i && !count_step) |=> $stable(invalid_symbol_count_q))
    else $error("read changed the symbol error counter");

  AST_XOVER_MANUAL: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && auto_crossover_disable_q) |=> mdix_active_o == $past(manual_crossover_select_q))
    else $error("manual crossover select not applied");

  AST_XOVER_AUTO: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    (ce_i && !auto_crossover_disable_q) |=> mdix_active_o == $past(auto_mdix_i))
    else $error("automatic crossover result not applied");

endmodule

`default_nettype wire

// ### verification/pvm_mgmt_model.sv
// Management controller model: whole-word register writes and reads.
// Assumes the block takes strobes on the rising edge and answers one cycle later.
`timescale 1ns/1ps
`default_nettype none

module pvm_mgmt_model (
  input wire logic clk_sys_i,
  input wire logic [15:0] reg_rdata_i,
  output logic [4:0] reg_addr_o,
  output logic reg_wr_o,
  output logic reg_rd_o,
  output logic [15:0] reg_wdata_o
);
  import pvm_pkg::*;

  // ==========================================================================
  // Bus cycles
  initial begin
    reg_addr_o = 5'h00;
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_wdata_o = 16'h0000;
  end

  task automatic wr_reg(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_wdata_o = (a == PVM_IDX_SPECIAL_MODES) ? (d | 16'h4000) : d;
    reg_wr_o = 1'b1;
    @(negedge clk_sys_i);
    reg_wr_o = 1'b0;
    // Stale data must not look valid
    reg_wdata_o = ~reg_wdata_o;
  endtask

  task automatic rd_reg(input logic [4:0] a, output logic [15:0] d);
    @(negedge clk_sys_i);
    reg_addr_o = a;
    reg_rd_o = 1'b1;
    @(negedge clk_sys_i);
    reg_rd_o = 1'b0;
    d = reg_rdata_i;
  endtask
endmodule

`default_nettype wire

// ### verification/tb_pvm_regs.sv
// Self-checking bench for the vendor mode/status registers.
// Assumes the management model drives the register port; line inputs driven here.
`timescale 1ns/1ps
`default_nettype none

module tb_pvm_regs;
  import pvm_pkg::*;
  logic clk_sys_i = 1'b0;
  logic rstn_i = 1'b0;
  logic soft_rst = 1'b0;
  logic ce = 1'b1;
  logic [2:0] mode_strap = 3'h5;
  logic addr_strap = 1'b1;
  logic speed_100 = 1'b1;
  logic isolate = 1'b1;
  logic energy = 1'b1;
  logic rx_packet = 1'b0;
  logic sym_err = 1'b0;
  logic rx_dv = 1'b0;
  logic [3:0] rx_data = 4'h0;
  logic auto_mdix = 1'b0;
  logic rx_pol = 1'b0;
  logic [4:0] reg_addr;
  logic reg_wr, reg_rd, edpd, irq_sel, lb_en, mdix, hb_en;
  logic [15:0] reg_wdata, reg_rdata;
  logic [2:0] op_mode;
  logic [4:0] mgmt_addr;
  logic [3:0] lb_data;
  int bad_count = 0;
  int n_checks = 0;

  always #4 clk_sys_i = ~clk_sys_i;

  // Short energy timeout keeps the run brief
  pvm_regs #(.ENERGY_CYCLES(16)) dut (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .ce_i(ce), .soft_rst_i(soft_rst),
    .reg_addr_i(reg_addr), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_wdata_i(reg_wdata), .reg_rdata_o(reg_rdata), .mode_strap_i(mode_strap),
    .addr_strap_i(addr_strap), .speed_100_i(speed_100), .isolate_i(isolate),
    .energy_detect_i(energy), .rx_packet_i(rx_packet), .rx_symbol_err_i(sym_err),
    .rx_dv_i(rx_dv), .rx_data_i(rx_data), .auto_mdix_i(auto_mdix),
    .rx_polarity_reversed_i(rx_pol), .energy_detect_powerdown_en_o(edpd),
    .irq_scheme_select_o(irq_sel), .op_mode_o(op_mode), .mgmt_address_o(mgmt_addr),
    .lb_tx_en_o(lb_en), .lb_tx_data_o(lb_data), .mdix_active_o(mdix),
    .heartbeat_test_en_o(hb_en)
  );

  pvm_mgmt_model u_mgmt (
    .clk_sys_i(clk_sys_i), .reg_rdata_i(reg_rdata), .reg_addr_o(reg_addr),
    .reg_wr_o(reg_wr), .reg_rd_o(reg_rd), .reg_wdata_o(reg_wdata)
  );

  // ==========================================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic rd_chk(input logic [4:0] a, input logic [15:0] exp, input string what);
    logic [15:0] d;
    u_mgmt.rd_reg(a, d);
    chk(d, exp, what);
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic pulse_err(input int n);
    repeat (n) begin
      @(negedge clk_sys_i);
      sym_err = 1'b1;
      @(negedge clk_sys_i);
      sym_err = 1'b0;
    end
  endtask

  task automatic hw_reset(input int n);
    @(negedge clk_sys_i);
    rstn_i = 1'b0;
    cyc(n);
    rstn_i = 1'b1;
    // Straps load on the first edge after release
    cyc(2);
  endtask

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  initial begin
    repeat (90000) @(posedge clk_sys_i);
    bad_count++;
    $display("MISMATCH t=%0t run timed out", $time);
    give_verdict();
  end

  // ==========================================================================
  // Tests
  initial begin
    hw_reset(20);
    rd_chk(PVM_IDX_MODE_CTL, 16'h0002, "mode reset");
    rd_chk(PVM_IDX_SPECIAL_MODES, 16'h40A1, "special reset");
    chk({8'h0, op_mode, mgmt_addr}, 16'h00A1, "strap outs");
    rd_chk(PVM_IDX_SYM_ERR, 16'h0000, "count reset");
    rd_chk(PVM_IDX_XOVER_CTL, 16'h0000, "xover reset");
    chk({15'h0, hb_en}, 16'h0001, "heartbeat reset");
    u_mgmt.wr_reg(5'h05, 16'hFFFF);
    u_mgmt.wr_reg(PVM_IDX_SYM_ERR, 16'hFFFF);
    rd_chk(5'h05, 16'h0000, "unmapped");
    rd_chk(PVM_IDX_SYM_ERR, 16'h0000, "count write");
    $display("test reset done");
    u_mgmt.wr_reg(PVM_IDX_MODE_CTL, 16'hFFFF);
    rd_chk(PVM_IDX_MODE_CTL, 16'h2243, "mode rw");
    chk({14'h0, edpd, irq_sel}, 16'h0003, "mode outs");
    u_mgmt.wr_reg(PVM_IDX_MODE_CTL, 16'h0200);
    chk({14'h0, edpd, irq_sel}, 16'h0000, "primary irq");
    u_mgmt.wr_reg(PVM_IDX_SPECIAL_MODES, 16'hBF55);
    rd_chk(PVM_IDX_SPECIAL_MODES, 16'h4055, "special rw");
    chk({8'h0, op_mode, mgmt_addr}, 16'h0055, "mode addr outs");
    $display("test registers done");
    @(negedge clk_sys_i);
    rx_dv = 1'b1;
    rx_data = 4'hA;
    cyc(1);
    chk({11'h0, lb_en, lb_data}, 16'h001A, "loopback isolated");
    speed_100 = 1'b0;
    cyc(1);
    chk({15'h0, lb_en}, 16'h0000, "loopback 10bt");
    speed_100 = 1'b1;
    rx_dv = 1'b0;
    $display("test loopback done");
    pulse_err(3);
    rx_packet = 1'b1;
    pulse_err(3);
    rx_packet = 1'b0;
    rd_chk(PVM_IDX_SYM_ERR, 16'h0004, "idle and packet");
    speed_100 = 1'b0;
    pulse_err(3);
    speed_100 = 1'b1;
    rd_chk(PVM_IDX_SYM_ERR, 16'h0004, "10bt hold");
    sym_err = 1'b1;
    cyc(65532);
    sym_err = 1'b0;
    rd_chk(PVM_IDX_SYM_ERR, 16'h0000, "wrap");
    pulse_err(1);
    rd_chk(PVM_IDX_SYM_ERR, 16'h0001, "after wrap");
    // Clock enable low: neither an error nor a write may land
    ce = 1'b0;
    sym_err = 1'b1;
    u_mgmt.wr_reg(PVM_IDX_MODE_CTL, 16'h2000);
    sym_err = 1'b0;
    ce = 1'b1;
    rd_chk(PVM_IDX_SYM_ERR, 16'h0001, "frozen count");
    rd_chk(PVM_IDX_MODE_CTL, 16'h0202, "frozen write");
    $display("test counter done");
    auto_mdix = 1'b1;
    cyc(1);
    chk({15'h0, mdix}, 16'h0001, "auto crossed");
    auto_mdix = 1'b0;
    cyc(1);
    chk({15'h0, mdix}, 16'h0000, "auto straight");
    rx_pol = 1'b1;
    u_mgmt.wr_reg(PVM_IDX_XOVER_CTL, 16'hFFFF);
    rd_chk(PVM_IDX_XOVER_CTL, 16'hA810, "xover rw");
    chk({14'h0, mdix, hb_en}, 16'h0002, "manual crossed");
    auto_mdix = 1'b1;
    u_mgmt.wr_reg(PVM_IDX_XOVER_CTL, 16'h8800);
    cyc(1);
    chk({15'h0, mdix}, 16'h0000, "manual straight");
    $display("test crossover done");
    u_mgmt.wr_reg(PVM_IDX_MODE_CTL, 16'h2241);
    u_mgmt.wr_reg(PVM_IDX_XOVER_CTL, 16'hA800);
    energy = 1'b0;
    cyc(12);
    rd_chk(PVM_IDX_MODE_CTL, 16'h2243, "energy held");
    cyc(10);
    rd_chk(PVM_IDX_MODE_CTL, 16'h2241, "energy lost");
    @(negedge clk_sys_i);
    soft_rst = 1'b1;
    @(negedge clk_sys_i);
    soft_rst = 1'b0;
    rd_chk(PVM_IDX_MODE_CTL, 16'h0000, "soft mode");
    rd_chk(PVM_IDX_SPECIAL_MODES, 16'h4055, "soft special");
    rd_chk(PVM_IDX_XOVER_CTL, 16'h0810, "soft xover");
    rd_chk(PVM_IDX_SYM_ERR, 16'h0000, "soft count");
    mode_strap = 3'h3;
    addr_strap = 1'b0;
    hw_reset(3);
    rd_chk(PVM_IDX_MODE_CTL, 16'h0002, "hw energy");
    rd_chk(PVM_IDX_SPECIAL_MODES, 16'h4060, "straps again");
    $display("test resets done");
    give_verdict();
  end
endmodule

`default_nettype wire
